// file: design/bbd_domain_ctrl.sv
// Battery backup domain control: supply switch, detectors, crystal, regs
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// - Main brown-out switches domain onto battery pin
// - Return to main after power, POR, BOR released
// - Ignore main-side inputs while main is low
// - Reset main-only logic on main power loss
// - Battery power-on sets backup power-on flag
// - Low battery voltage sets backup brown-out flag
// - Battery detector samples once per 1 Hz tick
// - Battery detector runs only on battery supply
// - Crystal, monitor, counter idle until software enables
// - Crystal gives full, 1.024 kHz, 1 Hz outputs
// - Counter clocked from 1 Hz or 1.024 kHz
// - Domain keeps counter, crystal, two byte registers
// - Check battery each main power-up; write-one clears
// - Domain reset clears crystal enables, select, ready
// - Without access only battery flags and access enable are reachable
// - Crystal failure flag clears only by domain reset
module bbd_domain_ctrl #(
  parameter int ULP_CYCLES = bbd_pkg::ULP_TICK_CYCLES,
  parameter int STARTUP_TICKS = bbd_pkg::XTAL_STARTUP_TICKS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_brownout_pin,
  input wire logic main_poweron_pin,
  input wire logic battery_present_pin,
  input wire logic battery_low_pin,
  input wire logic crystal_fault_pin,
  output logic supply_on_battery,
  output logic domain_isolate,
  output logic main_domain_reset,
  output logic battery_brownout_detector_enable,
  output logic crystal_osc_enable,
  output logic osc_fail_detect_enable,
  output logic crystal_tick,
  output logic tick_1k024,
  output logic tick_1hz,
  output logic counter_tick,
  output logic [31:0] backup_time_counter
);
  // Pin synchronisers: bit 0 brown-out, 1 main POR, 2 battery present,
  // 3 battery low, 4 crystal fault
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic main_bod;
  logic main_por;
  logic batt_ok;
  logic batt_low;
  logic xtal_fault;

  // Main POR reads as active until the flops fill, so the battery check
  // at the first main reset release sees a settled presence pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 5'h02;
      sync2 <= 5'h02;
    end else begin
      sync1 <= {crystal_fault_pin, battery_low_pin, battery_present_pin,
                main_poweron_pin, main_brownout_pin};
      sync2 <= sync1;
    end
  end
  assign main_bod = sync2[0];
  assign main_por = sync2[1];
  assign batt_ok = sync2[2];
  assign batt_low = sync2[3];
  assign xtal_fault = sync2[4];

  // Supply switch state machine
  bbd_pkg::bbd_pwr_state_t state;
  bbd_pkg::bbd_pwr_state_t next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      bbd_pkg::PWR_MAIN: begin
        if (main_bod) begin
          next_state = bbd_pkg::PWR_ISOLATE;
        end
      end
      bbd_pkg::PWR_ISOLATE: begin
        next_state = bbd_pkg::PWR_BATTERY;
      end
      bbd_pkg::PWR_BATTERY: begin
        if (!main_bod && !main_por) begin
          next_state = bbd_pkg::PWR_RESTORE;
        end
      end
      bbd_pkg::PWR_RESTORE: begin
        // Supply is back on main; isolation drops one cycle later
        next_state = main_bod ? bbd_pkg::PWR_BATTERY : bbd_pkg::PWR_MAIN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= bbd_pkg::PWR_MAIN;
    end else begin
      state <= next_state;
    end
  end

  assign supply_on_battery = (state == bbd_pkg::PWR_BATTERY);
  assign domain_isolate = (state != bbd_pkg::PWR_MAIN);
  assign main_domain_reset = main_bod || main_por;
  assign battery_brownout_detector_enable = supply_on_battery;

  // Slow clock enables
  logic ulp_tick;
  logic osc_en;

  bbd_tick_div #(.W(27), .DIV(27'(ULP_CYCLES))) u_ulp_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .en(1'b1),
    .step(1'b1),
    .tick(ulp_tick)
  );
  bbd_tick_div #(.W(12), .DIV(12'(bbd_pkg::XTAL_TICK_CYCLES))) u_xtal_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .en(osc_en),
    .step(1'b1),
    .tick(crystal_tick)
  );
  bbd_tick_div #(.W(6), .DIV(6'(bbd_pkg::XTAL_PER_1K024))) u_k1024_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .en(osc_en),
    .step(crystal_tick),
    .tick(tick_1k024)
  );
  bbd_tick_div #(.W(11), .DIV(11'(bbd_pkg::K1024_PER_1HZ))) u_hz_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .en(osc_en),
    .step(tick_1k024),
    .tick(tick_1hz)
  );

  // Register state
  logic acc_en;
  logic fd_en;
  logic clk_sel;
  logic xtal_rdy;
  logic xtal_fail;
  logic flag_pon;
  logic flag_bod;
  logic flag_nobat;
  logic cnt_run;
  logic main_rst_q;
  logic [7:0] backup0;
  logic [7:0] backup1;
  logic [7:0] startup;
  logic [31:0] count;
  logic [31:0] rdata;
  logic next_acc_en;
  logic next_osc_en;
  logic next_fd_en;
  logic next_clk_sel;
  logic next_xtal_rdy;
  logic next_xtal_fail;
  logic next_flag_pon;
  logic next_flag_bod;
  logic next_flag_nobat;
  logic next_cnt_run;
  logic [7:0] next_backup0;
  logic [7:0] next_backup1;
  logic [7:0] next_startup;
  logic [31:0] next_count;
  logic [31:0] next_rdata;

  // Bus decode; main-side writes are dropped while isolated
  logic [5:0] idx;
  logic mapped;
  logic wr;
  logic wr_full;
  logic dom_rst;

  assign idx = paddr[7:2];
  assign mapped = (idx <= bbd_pkg::IDX_COUNT_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite && !domain_isolate
              && !main_domain_reset;
  assign wr_full = wr && acc_en;
  // Setting the oscillator or fail-detect enable in the same write blocks the domain reset
  assign dom_rst = wr_full && (idx == bbd_pkg::IDX_CTRL)
                   && pwdata[bbd_pkg::CTRL_DOMAIN_RESET]
                   && !pwdata[bbd_pkg::CTRL_OSC_ENABLE]
                   && !pwdata[bbd_pkg::CTRL_FAIL_DETECT_EN];

  assign counter_tick = clk_sel ? tick_1k024 : tick_1hz;
  assign crystal_osc_enable = osc_en;
  assign osc_fail_detect_enable = fd_en;
  assign backup_time_counter = count;
  assign prdata = rdata;

  always_comb begin
    next_acc_en = acc_en;
    next_osc_en = osc_en;
    next_fd_en = fd_en;
    next_clk_sel = clk_sel;
    next_xtal_rdy = xtal_rdy;
    next_xtal_fail = xtal_fail;
    next_flag_pon = flag_pon;
    next_flag_bod = flag_bod;
    next_flag_nobat = flag_nobat;
    next_cnt_run = cnt_run;
    next_backup0 = backup0;
    next_backup1 = backup1;
    next_startup = startup;
    next_count = count;
    next_rdata = 32'h0000_0000;
    // Write-one-clear of the battery flags is allowed without access
    if (wr && idx == bbd_pkg::IDX_STATUS) begin
      if (pwdata[bbd_pkg::STAT_POWERON]) next_flag_pon = 1'b0;
      if (pwdata[bbd_pkg::STAT_BROWNOUT]) next_flag_bod = 1'b0;
      if (pwdata[bbd_pkg::STAT_NO_BATTERY]) next_flag_nobat = 1'b0;
      if (acc_en && pwdata[bbd_pkg::STAT_XTAL_READY]) begin
        next_xtal_rdy = 1'b0;
      end
    end
    if (wr && idx == bbd_pkg::IDX_CTRL) begin
      next_acc_en = pwdata[bbd_pkg::CTRL_ACCESS_ENABLE];
    end
    if (wr_full && idx == bbd_pkg::IDX_CTRL) begin
      if (pwdata[bbd_pkg::CTRL_OSC_ENABLE]) next_osc_en = 1'b1;
      if (pwdata[bbd_pkg::CTRL_FAIL_DETECT_EN]) next_fd_en = 1'b1;
      // Select is frozen once the oscillator runs, to avoid a glitch
      if (!osc_en) next_clk_sel = pwdata[bbd_pkg::CTRL_CLOCK_SELECT];
    end
    if (wr_full && idx == bbd_pkg::IDX_BACKUP0) next_backup0 = pwdata[7:0];
    if (wr_full && idx == bbd_pkg::IDX_BACKUP1) next_backup1 = pwdata[7:0];
    if (wr_full && idx == bbd_pkg::IDX_COUNT_CTRL) begin
      next_cnt_run = pwdata[bbd_pkg::CCTRL_RUN];
    end
    // Counter advances only when software has started it
    if (wr_full && idx == bbd_pkg::IDX_COUNT) begin
      next_count = pwdata;
    end else if (cnt_run && counter_tick) begin
      next_count = count + 32'h0000_0001;
    end
    // Crystal start-up: ready once enough crystal periods have passed
    if (osc_en && crystal_tick && startup != 8'(STARTUP_TICKS)) begin
      next_startup = startup + 8'h01;
      if (startup == 8'(STARTUP_TICKS - 1)) next_xtal_rdy = 1'b1;
    end
    if (fd_en && xtal_fault) next_xtal_fail = 1'b1;
    if (dom_rst) begin
      next_osc_en = 1'b0;
      next_fd_en = 1'b0;
      next_clk_sel = 1'b0;
      next_xtal_rdy = 1'b0;
      next_xtal_fail = 1'b0;
      next_startup = 8'h00;
    end
    // Detector events set their flags after any clear in this cycle
    if (ulp_tick && supply_on_battery && batt_low) begin
      next_flag_bod = 1'b1;
    end
    if (main_rst_q && !main_domain_reset && !batt_ok) begin
      next_flag_nobat = 1'b1;
    end
    if (main_domain_reset) next_acc_en = 1'b0;
    // Read data is captured in the setup phase for a zero-wait access
    if (psel && !penable && !pwrite) begin
      unique case (idx)
        bbd_pkg::IDX_CTRL: begin
          next_rdata[bbd_pkg::CTRL_ACCESS_ENABLE] = acc_en;
          if (acc_en) begin
            next_rdata[bbd_pkg::CTRL_FAIL_DETECT_EN] = fd_en;
            next_rdata[bbd_pkg::CTRL_OSC_ENABLE] = osc_en;
            next_rdata[bbd_pkg::CTRL_CLOCK_SELECT] = clk_sel;
          end
        end
        bbd_pkg::IDX_STATUS: begin
          next_rdata[bbd_pkg::STAT_POWERON] = flag_pon;
          next_rdata[bbd_pkg::STAT_BROWNOUT] = flag_bod;
          next_rdata[bbd_pkg::STAT_NO_BATTERY] = flag_nobat;
          if (acc_en) begin
            next_rdata[bbd_pkg::STAT_XTAL_FAIL] = xtal_fail;
            next_rdata[bbd_pkg::STAT_XTAL_READY] = xtal_rdy;
          end
        end
        bbd_pkg::IDX_BACKUP0: next_rdata[7:0] = acc_en ? backup0 : 8'h00;
        bbd_pkg::IDX_BACKUP1: next_rdata[7:0] = acc_en ? backup1 : 8'h00;
        bbd_pkg::IDX_COUNT: next_rdata = acc_en ? count : 32'h0000_0000;
        bbd_pkg::IDX_COUNT_CTRL: begin
          next_rdata[bbd_pkg::CCTRL_RUN] = acc_en && cnt_run;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_en <= 1'b0;
      osc_en <= 1'b0;
      fd_en <= 1'b0;
      clk_sel <= 1'b0;
      xtal_rdy <= 1'b0;
      xtal_fail <= 1'b0;
      flag_pon <= bbd_pkg::POWERON_FLAG_RESET;
      flag_bod <= 1'b0;
      flag_nobat <= 1'b0;
      cnt_run <= 1'b0;
      main_rst_q <= 1'b1;
      backup0 <= bbd_pkg::BACKUP_RESET;
      backup1 <= bbd_pkg::BACKUP_RESET;
      startup <= 8'h00;
      count <= bbd_pkg::COUNT_RESET;
      rdata <= 32'h0000_0000;
    end else begin
      acc_en <= next_acc_en;
      osc_en <= next_osc_en;
      fd_en <= next_fd_en;
      clk_sel <= next_clk_sel;
      xtal_rdy <= next_xtal_rdy;
      xtal_fail <= next_xtal_fail;
      flag_pon <= next_flag_pon;
      flag_bod <= next_flag_bod;
      flag_nobat <= next_flag_nobat;
      cnt_run <= next_cnt_run;
      main_rst_q <= main_domain_reset;
      backup0 <= next_backup0;
      backup1 <= next_backup1;
      startup <= next_startup;
      count <= next_count;
      rdata <= next_rdata;
    end
  end
endmodule

// file: design/bbd_pkg.sv
// Constants and types shared by the backup domain control files
package bbd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_BACKUP0 = 6'h02;
  localparam logic [5:0] IDX_BACKUP1 = 6'h03;
  localparam logic [5:0] IDX_COUNT = 6'h04;
  localparam logic [5:0] IDX_COUNT_CTRL = 6'h05;
  // Control register fields
  localparam int CTRL_DOMAIN_RESET = 0;
  localparam int CTRL_ACCESS_ENABLE = 1;
  localparam int CTRL_FAIL_DETECT_EN = 2;
  localparam int CTRL_OSC_ENABLE = 3;
  localparam int CTRL_CLOCK_SELECT = 4;
  // Status register fields
  localparam int STAT_POWERON = 0;
  localparam int STAT_BROWNOUT = 1;
  localparam int STAT_XTAL_FAIL = 2;
  localparam int STAT_XTAL_READY = 3;
  localparam int STAT_NO_BATTERY = 7;
  // Counter control fields
  localparam int CCTRL_RUN = 0;
  // Reset values
  localparam logic [7:0] BACKUP_RESET = 8'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic POWERON_FLAG_RESET = 1'b1;
  // Timing
  localparam int CORE_CLK_HZ = 100_000_000;
  localparam int XTAL_HZ = 32_768;
  localparam int ULP_TICK_HZ = 1;
  localparam int XTAL_TICK_CYCLES = CORE_CLK_HZ / XTAL_HZ;
  localparam int ULP_TICK_CYCLES = CORE_CLK_HZ / ULP_TICK_HZ;
  localparam int XTAL_PER_1K024 = 32;
  localparam int K1024_PER_1HZ = 1024;
  localparam int XTAL_STARTUP_TICKS = 32;

  typedef enum logic [1:0] {
    PWR_MAIN,
    PWR_ISOLATE,
    PWR_BATTERY,
    PWR_RESTORE
  } bbd_pwr_state_t;
endpackage

// file: design/bbd_tick_div.sv
// Enable-pulse divider: counts step pulses, emits one tick per DIV steps
`timescale 1ns/10ps
module bbd_tick_div #(
  parameter int W = 16,
  parameter logic [W-1:0] DIV = '1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic step,
  output logic tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic at_end;

  assign at_end = (cnt == DIV - W'(1));
  assign tick = en && step && at_end;

  always_comb begin
    next_cnt = cnt;
    if (!en) begin
      // Restart from zero so a fresh enable gives a full first period
      next_cnt = '0;
    end else if (step) begin
      next_cnt = at_end ? '0 : cnt + W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// file: sim/bbd_domain_ctrl_checker.sv
// Port-level assertions for the backup domain control block
`timescale 1ns/10ps
module bbd_domain_ctrl_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic main_brownout_pin,
  input wire logic supply_on_battery,
  input wire logic domain_isolate,
  input wire logic main_domain_reset,
  input wire logic battery_brownout_detector_enable,
  input wire logic crystal_osc_enable,
  input wire logic osc_fail_detect_enable,
  input wire logic crystal_tick,
  input wire logic tick_1k024,
  input wire logic tick_1hz,
  input wire logic counter_tick
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
  // Two sync flops, one isolate cycle, then the switch
  property p_to_battery;
    main_brownout_pin [*5] |-> supply_on_battery;
  endproperty
  a_to_battery: assert property (p_to_battery)
    else $error("domain not on battery after main brown-out");
  property p_back_main;
    $fell(supply_on_battery) |-> !$past(main_domain_reset);
  endproperty
  a_back_main: assert property (p_back_main)
    else $error("left battery while main reset active");
  property p_iso_batt;
    supply_on_battery |-> domain_isolate;
  endproperty
  a_iso_batt: assert property (p_iso_batt)
    else $error("main inputs not isolated on battery");
  property p_iso_first;
    $rose(supply_on_battery) |-> $past(domain_isolate);
  endproperty
  a_iso_first: assert property (p_iso_first)
    else $error("supply switched before isolation");
  property p_main_rst;
    main_brownout_pin [*3] |-> main_domain_reset;
  endproperty
  a_main_rst: assert property (p_main_rst)
    else $error("main-only logic not reset on power loss");
  property p_bbod_en;
    battery_brownout_detector_enable == supply_on_battery;
  endproperty
  a_bbod_en: assert property (p_bbod_en)
    else $error("battery detector enable wrong for supply");
  property p_osc_set;
    $rose(crystal_osc_enable) |->
      $past(ctrl_wr && pwdata[bbd_pkg::CTRL_OSC_ENABLE]);
  endproperty
  a_osc_set: assert property (p_osc_set)
    else $error("oscillator enabled without a write");
  property p_fd_set;
    $rose(osc_fail_detect_enable) |->
      $past(ctrl_wr && pwdata[bbd_pkg::CTRL_FAIL_DETECT_EN]);
  endproperty
  a_fd_set: assert property (p_fd_set)
    else $error("fail monitor enabled without a write");
  property p_idle;
    !crystal_osc_enable && $past(!crystal_osc_enable) |-> !crystal_tick;
  endproperty
  a_idle: assert property (p_idle)
    else $error("crystal ticks while disabled");
  property p_cnt_src;
    counter_tick |-> tick_1hz || tick_1k024;
  endproperty
  a_cnt_src: assert property (p_cnt_src)
    else $error("counter ticked from no crystal output");
  property p_slverr;
    psel && penable && paddr[7:2] > 6'h05 |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("no error on unmapped access");
endmodule

bind bbd_domain_ctrl bbd_domain_ctrl_checker u_chk (.core_clk, .rst_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .main_brownout_pin,
  .supply_on_battery, .domain_isolate, .main_domain_reset,
  .battery_brownout_detector_enable, .crystal_osc_enable,
  .osc_fail_detect_enable, .crystal_tick, .tick_1k024, .tick_1hz,
  .counter_tick);

// file: sim/bbd_supply_model.sv
// Supply-side model: main rail detectors and backup battery pins
`timescale 1ns/10ps
module bbd_supply_model (
  input wire logic core_clk,
  input wire logic main_ok,
  input wire logic bat_ok,
  input wire logic bat_low,
  output logic main_brownout_pin,
  output logic main_poweron_pin,
  output logic battery_present_pin,
  output logic battery_low_pin
);
  logic [2:0] por_hold = 3'h0;
  // Main detector left enabled so the switch can follow the rail
  assign main_brownout_pin = !main_ok;
  // Power-on reset outlasts the brown-out by a few cycles
  always @(posedge core_clk) begin
    if (!main_ok) begin
      por_hold <= 3'h4;
    end else if (por_hold != 3'h0) begin
      por_hold <= por_hold - 3'h1;
    end
  end
  assign main_poweron_pin = (por_hold != 3'h0);
  assign battery_present_pin = bat_ok;
  // A missing battery reads as a flat one
  assign battery_low_pin = bat_low || !bat_ok;
endmodule

// file: sim/test_battery_backup_domain_control.sv
// Self-checking bench for the backup domain control block
`timescale 1ns/10ps
module test_battery_backup_domain_control;
  localparam int ULP = 50;
  localparam int STARTUP = 2;
  localparam logic [7:0] A_CTRL = {bbd_pkg::IDX_CTRL, 2'b00};
  localparam logic [7:0] A_STAT = {bbd_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0] A_BK0 = {bbd_pkg::IDX_BACKUP0, 2'b00};
  localparam logic [7:0] A_BK1 = {bbd_pkg::IDX_BACKUP1, 2'b00};
  localparam logic [7:0] A_CNT = {bbd_pkg::IDX_COUNT, 2'b00};
  localparam logic [7:0] A_CCTRL = {bbd_pkg::IDX_COUNT_CTRL, 2'b00};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic main_ok = 1'b1;
  logic bat_ok = 1'b1;
  logic bat_low = 1'b0;
  logic crystal_fault_pin = 1'b0;
  logic [31:0] prdata, backup_time_counter, rd;
  logic pready, pslverr, er, main_brownout_pin, main_poweron_pin;
  logic battery_present_pin, battery_low_pin, supply_on_battery;
  logic domain_isolate, main_domain_reset, battery_brownout_detector_enable;
  logic crystal_osc_enable, osc_fail_detect_enable, crystal_tick;
  logic tick_1k024, tick_1hz, counter_tick;
  int err_count = 0;
  int tests_run = 0;

  always #5 core_clk = ~core_clk;

  bbd_supply_model supply (.core_clk, .main_ok, .bat_ok, .bat_low,
    .main_brownout_pin, .main_poweron_pin, .battery_present_pin,
    .battery_low_pin);

  bbd_domain_ctrl #(.ULP_CYCLES(ULP), .STARTUP_TICKS(STARTUP)) dut (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_brownout_pin, .main_poweron_pin,
    .battery_present_pin, .battery_low_pin, .crystal_fault_pin,
    .supply_on_battery, .domain_isolate, .main_domain_reset,
    .battery_brownout_detector_enable, .crystal_osc_enable,
    .osc_fail_detect_enable, .crystal_tick, .tick_1k024, .tick_1hz,
    .counter_tick, .backup_time_counter);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Answer is taken at the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_supply(input logic lvl);
    int n;
    n = 0;
    while (supply_on_battery !== lvl && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk({31'h0, supply_on_battery}, {31'h0, lvl});
    @(posedge core_clk);
  endtask

  task automatic t_regs;
    rchk(A_STAT, 32'h0000_0001);
    apb(1'b1, A_BK0, 32'h0000_00A5);
    apb(1'b1, A_CTRL, 32'h0000_0002);
    rchk(A_BK0, 32'h0000_0000);
    apb(1'b1, A_BK0, 32'h0000_00A5);
    apb(1'b1, A_BK1, 32'h0000_003C);
    rchk(A_BK0, 32'h0000_00A5);
    rchk(A_BK1, 32'h0000_003C);
    rchk(8'h18, 32'h0000_0000);
    chk({31'h0, er}, 32'h1);
  endtask

  task automatic t_osc;
    apb(1'b1, A_CTRL, 32'h0000_000E);
    @(negedge core_clk);
    chk({31'h0, crystal_osc_enable}, 32'h1);
    chk({31'h0, osc_fail_detect_enable}, 32'h1);
    apb(1'b1, A_CTRL, 32'h0000_0012);
    rchk(A_CTRL, 32'h0000_000E);
    apb(1'b1, A_CTRL, 32'h0000_000B);
    rchk(A_CTRL, 32'h0000_000E);
    repeat (STARTUP * bbd_pkg::XTAL_TICK_CYCLES + 100) @(posedge core_clk);
    rchk(A_STAT, 32'h0000_0009);
    crystal_fault_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    crystal_fault_pin <= 1'b0;
    apb(1'b1, A_STAT, 32'h0000_0004);
    rchk(A_STAT, 32'h0000_000D);
    apb(1'b1, A_CTRL, 32'h0000_0003);
    @(negedge core_clk);
    chk({31'h0, crystal_osc_enable}, 32'h0);
    chk({31'h0, osc_fail_detect_enable}, 32'h0);
    rchk(A_CTRL, 32'h0000_0002);
    rchk(A_STAT, 32'h0000_0001);
    apb(1'b1, A_STAT, 32'h0000_0001);
    rchk(A_STAT, 32'h0000_0000);
  endtask

  // Crystal off: a running counter must not move on the 1.024 kHz select
  task automatic t_count;
    rchk(A_STAT, 32'h0000_0000);
    apb(1'b1, A_CTRL, 32'h0000_0012);
    rchk(A_CTRL, 32'h0000_0012);
    apb(1'b1, A_CNT, 32'h1234_5678);
    apb(1'b1, A_CCTRL, 32'h0000_0001);
    repeat (20) @(posedge core_clk);
    chk(backup_time_counter, 32'h1234_5678);
    rchk(A_CNT, 32'h1234_5678);
    rchk(A_CCTRL, 32'h0000_0001);
    apb(1'b1, A_CCTRL, 32'h0000_0000);
    apb(1'b1, A_CTRL, 32'h0000_0003);
    rchk(A_CTRL, 32'h0000_0002);
  endtask

  task automatic t_power;
    bat_low <= 1'b1;
    repeat (3 * ULP) @(posedge core_clk);
    rchk(A_STAT, 32'h0000_0000);
    main_ok <= 1'b0;
    wait_supply(1'b1);
    @(negedge core_clk);
    chk({31'h0, domain_isolate}, 32'h1);
    chk({31'h0, main_domain_reset}, 32'h1);
    chk({31'h0, battery_brownout_detector_enable}, 32'h1);
    apb(1'b1, A_BK0, 32'h0000_00FF);
    repeat (3 * ULP) @(posedge core_clk);
    bat_low <= 1'b0;
    main_ok <= 1'b1;
    wait_supply(1'b0);
    rchk(A_CTRL, 32'h0000_0000);
    rchk(A_STAT, 32'h0000_0002);
    apb(1'b1, A_CTRL, 32'h0000_0002);
    rchk(A_BK0, 32'h0000_00A5);
  endtask

  task automatic t_nobatt;
    bat_ok <= 1'b0;
    main_ok <= 1'b0;
    wait_supply(1'b1);
    main_ok <= 1'b1;
    wait_supply(1'b0);
    repeat (4) @(posedge core_clk);
    rchk(A_STAT, 32'h0000_0082);
    bat_ok <= 1'b1;
    apb(1'b1, A_STAT, 32'h0000_0082);
    rchk(A_STAT, 32'h0000_0000);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs;
    t_osc;
    t_count;
    t_power;
    t_nobatt;
    tally_and_finish;
  end

  // Whole run needs about 7k cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    tally_and_finish;
  end
endmodule
